// ===== dsb_pkg.sv
// dsb_pkg: constants and types shared by the sector buffer host end and device end
// assumes one 250 MHz clock for both ends
package dsb_pkg;
   // clock and cell timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int CELL_NS       = 100;
   localparam int CELL_CYC      = CELL_NS / CLK_PERIOD_NS;
   localparam logic [4:0] CELL_LAST = 5'(CELL_CYC - 1);
   // buffer geometry
   localparam int BUF_BYTES  = 1024;
   localparam int ADDR_W     = 10;
   localparam logic [ADDR_W-1:0] SECTOR_BYTES = 10'h200;
   localparam logic [ADDR_W-1:0] SECTOR_LAST  = 10'h1FF;
   // task file register selects
   localparam logic [2:0] TF_DATA  = 3'h0;
   localparam logic [2:0] TF_CMD   = 3'h7;
   // command codes, values arbitrary
   localparam logic [7:0] CMD_WRITE_SECTOR = 8'h30;
   localparam logic [7:0] CMD_READ_SECTOR  = 8'h20;
   // device status byte bit positions
   localparam int ST_BUSY  = 7;
   localparam int ST_DRQ   = 3;
   localparam int ST_IRQ   = 1;
   localparam int ST_READY = 0;
   // host software register map
   localparam logic [3:0] HOST_STATUS = 4'h8;
   localparam logic [7:0] RESET_BYTE  = 8'h00;
   // device sequencer states
   typedef enum logic [2:0] {
      DSB_IDLE    = 3'h0,
      DSB_W_LOAD  = 3'h1,
      DSB_W_SEEK  = 3'h2,
      DSB_W_ENC   = 3'h3,
      DSB_R_SEEK  = 3'h4,
      DSB_R_FILL  = 3'h5,
      DSB_R_DRAIN = 3'h6
   } dsb_state_e;
   // buffer counter advance
   function automatic logic [ADDR_W-1:0] dsb_inc(input logic [ADDR_W-1:0] a);
      dsb_inc = a + 10'h001;
   endfunction : dsb_inc
endpackage : dsb_pkg

// ===== dsb_if.sv
// dsb_if: expansion bus link between host end and device end
// assumes both ends run on the same clock; resolves the busy line
`timescale 1ns/1ps
interface dsb_if;
   logic [2:0] task_reg_select_lines;
   logic       host_write_strobe;
   logic       host_read_strobe;
   logic [7:0] host_wdata;
   logic [7:0] host_rdata;
   logic       buffer_data_request;
   logic       buffer_ready_flag;
   logic       buffer_ownership_select;
   logic       buffer_counter_clear;
   logic       command_done_irq;
   logic       busy_o;
   logic       busy_oe_n;
   logic       busy_flag_line;

   assign busy_flag_line = (!busy_oe_n) ? busy_o : 1'b0;

   modport dev (
      input  task_reg_select_lines, host_write_strobe, host_read_strobe, host_wdata,
      output host_rdata, buffer_data_request, buffer_ready_flag, buffer_ownership_select,
      output buffer_counter_clear, command_done_irq, busy_o, busy_oe_n
   );
   modport host (
      output task_reg_select_lines, host_write_strobe, host_read_strobe, host_wdata,
      input  host_rdata, buffer_data_request, buffer_ready_flag, buffer_ownership_select,
      input  buffer_counter_clear, command_done_irq, busy_flag_line
   );
endinterface : dsb_if

// ===== dsb_device.sv
// dsb_device: disk controller end with dual-port sector buffer and mfm write encoder
// assumes the host keeps to the task file protocol; seek_done comes from a drive pin
//
// Overview of operation
// - one kilobyte byte-wide buffer shared by both
// - write: host fills sector before disk write
// - clear strobe zeroes counter before each pass
// - request line shows empty buffer on write
// - select high gives host the buffer
// - host write stores byte, advances counter
// - ready flag set when write fill completes
// - select low: host cut off, busy driven
// - after disk write, return buffer, drop busy
// - completion interrupt after write command
// - read: core fills buffer from disk first
// - then clear, return buffer, raise request
// - host read returns byte, advances counter
// - ready flag set when host empties buffer
// - interrupt ends read after host drains
// - write: seek, read buffer, encode, write
// - clock only when both data cells empty
// - cell clock low data, high clock
// - each cell lasts 100 ns; here the data cell of each byte's last bit lasts 104 ns, except in the sector's last byte
// - host uses three selects, two strobes
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
module dsb_device
   import dsb_pkg::*;
(
   // clock, reset, enable
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       ce,
   // host link
   dsb_if.dev              bus,
   // drive side
   input  wire logic       seek_done,
   input  wire logic       disk_rd_valid,
   input  wire logic [7:0] disk_rd_byte,
   output logic            write_gate,
   output logic            write_cell_clock,
   output logic            mfm_wr_data,
   output logic            core_buffer_read_strobe,
   output logic            core_buffer_write_strobe
);
   dsb_state_e        state_r;
   logic [ADDR_W-1:0] addr_r;
   logic [7:0]        mem_r [0:BUF_BYTES-1];
   logic [7:0]        tf_r  [1:6];
   logic [7:0]        rdata_r;
   logic              own_r, drq_r, rdy_r, irq_r, clr_r;
   logic [2:0]        sync_r;
   logic              seek_s_r;
   logic              need_byte_r, phase_clk_r, prev_bit_r, enc_on_r;
   logic [4:0]        cell_r;
   logic [2:0]        bit_r;
   logic [7:0]        shift_r;
   logic              wg_r, wcc_r, mfm_r;
   logic              host_wr_data, host_rd_data, core_wr, core_rd, cmd_wr, stat_rd;
   logic              last, clr_now, enc_done, cell_end;

   ////////////////////////////////////////////////////////////////////////////////
   // access decode
   assign host_wr_data = bus.host_write_strobe && bus.task_reg_select_lines == TF_DATA
                         && own_r && state_r == DSB_W_LOAD;
   assign host_rd_data = bus.host_read_strobe && bus.task_reg_select_lines == TF_DATA
                         && own_r && state_r == DSB_R_DRAIN;
   assign core_wr  = state_r == DSB_R_FILL && disk_rd_valid;
   assign core_rd  = state_r == DSB_W_ENC && need_byte_r;
   assign cmd_wr   = bus.host_write_strobe && bus.task_reg_select_lines == TF_CMD
                     && state_r == DSB_IDLE;
   assign stat_rd  = bus.host_read_strobe && bus.task_reg_select_lines == TF_CMD;
   assign last     = addr_r == SECTOR_LAST;
   assign clr_now  = cmd_wr || (host_wr_data && last) || (core_wr && last);
   assign cell_end = cell_r == CELL_LAST;
   assign enc_done = enc_on_r && !need_byte_r && cell_end && !phase_clk_r
                     && bit_r == 3'h7 && addr_r == SECTOR_BYTES;

   ////////////////////////////////////////////////////////////////////////////////
   // seek complete synchroniser
   always_ff @(posedge clk) begin
      if (reset) begin
         sync_r   <= 3'h0;
         seek_s_r <= 1'b0;
      end else if (ce) begin
         sync_r <= {sync_r[1:0], seek_done};
         if (sync_r[1] == sync_r[2]) begin
            seek_s_r <= sync_r[2];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sequencer
   always_ff @(posedge clk) begin
      if (reset) begin
         state_r <= DSB_IDLE;
         own_r   <= 1'b1;
         drq_r   <= 1'b0;
         rdy_r   <= 1'b0;
         irq_r   <= 1'b0;
         clr_r   <= 1'b0;
      end else if (ce) begin
         clr_r <= clr_now;
         if (stat_rd) begin
            irq_r <= 1'b0;
         end
         unique case (state_r)
            DSB_IDLE: begin
               if (cmd_wr && bus.host_wdata == CMD_WRITE_SECTOR) begin
                  state_r <= DSB_W_LOAD;
                  own_r   <= 1'b1;
                  drq_r   <= 1'b1;
                  rdy_r   <= 1'b0;
               end else if (cmd_wr && bus.host_wdata == CMD_READ_SECTOR) begin
                  state_r <= DSB_R_SEEK;
                  own_r   <= 1'b0;
                  rdy_r   <= 1'b0;
               end
            end
            DSB_W_LOAD: begin
               if (host_wr_data && last) begin
                  state_r <= DSB_W_SEEK;
                  rdy_r   <= 1'b1;
                  drq_r   <= 1'b0;
                  own_r   <= 1'b0;
               end
            end
            DSB_W_SEEK: begin
               if (seek_s_r) begin
                  state_r <= DSB_W_ENC;
               end
            end
            DSB_W_ENC: begin
               if (enc_done) begin
                  state_r <= DSB_IDLE;
                  own_r   <= 1'b1;
                  rdy_r   <= 1'b0;
                  irq_r   <= 1'b1;
               end
            end
            DSB_R_SEEK: begin
               if (seek_s_r) begin
                  state_r <= DSB_R_FILL;
               end
            end
            DSB_R_FILL: begin
               if (core_wr && last) begin
                  state_r <= DSB_R_DRAIN;
                  rdy_r   <= 1'b1;
                  own_r   <= 1'b1;
                  drq_r   <= 1'b1;
               end
            end
            DSB_R_DRAIN: begin
               if (host_rd_data && last) begin
                  state_r <= DSB_IDLE;
                  drq_r   <= 1'b0;
                  rdy_r   <= 1'b1;
                  irq_r   <= 1'b1;
               end else if (host_rd_data && addr_r == 10'h000) begin
                  rdy_r <= 1'b0;
               end
            end
            default: begin
               state_r <= DSB_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // buffer address counter
   always_ff @(posedge clk) begin
      if (reset) begin
         addr_r <= '0;
      end else if (ce) begin
         if (clr_now) begin
            addr_r <= '0;
         end else if (host_wr_data || host_rd_data || core_wr || core_rd) begin
            addr_r <= dsb_inc(addr_r);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // buffer storage
   always_ff @(posedge clk) begin
      if (ce) begin
         if (host_wr_data) begin
            mem_r[addr_r] <= bus.host_wdata;
         end else if (core_wr) begin
            mem_r[addr_r] <= disk_rd_byte;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // task file registers and read data
   always_ff @(posedge clk) begin
      if (reset) begin
         for (int i = 1; i <= 6; i++) begin
            tf_r[i] <= RESET_BYTE;
         end
      end else if (ce) begin
         if (bus.host_write_strobe && bus.task_reg_select_lines != TF_DATA
             && bus.task_reg_select_lines != TF_CMD) begin
            tf_r[bus.task_reg_select_lines] <= bus.host_wdata;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rdata_r <= RESET_BYTE;
      end else if (ce) begin
         if (host_rd_data) begin
            rdata_r <= mem_r[addr_r];
         end else if (stat_rd) begin
            rdata_r           <= RESET_BYTE;
            rdata_r[ST_BUSY]  <= !own_r;
            rdata_r[ST_DRQ]   <= drq_r;
            rdata_r[ST_IRQ]   <= irq_r;
            rdata_r[ST_READY] <= rdy_r;
         end else if (bus.host_read_strobe && bus.task_reg_select_lines == TF_DATA) begin
            rdata_r          <= RESET_BYTE;
            rdata_r[ST_BUSY] <= !own_r;
         end else if (bus.host_read_strobe) begin
            rdata_r <= tf_r[bus.task_reg_select_lines];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // mfm serialiser
   always_ff @(posedge clk) begin
      if (reset) begin
         enc_on_r    <= 1'b0;
         need_byte_r <= 1'b0;
         phase_clk_r <= 1'b1;
         prev_bit_r  <= 1'b0;
         cell_r      <= '0;
         bit_r       <= '0;
         shift_r     <= RESET_BYTE;
      end else if (ce) begin
         if (state_r == DSB_W_SEEK && seek_s_r) begin
            enc_on_r    <= 1'b1;
            need_byte_r <= 1'b1;
            prev_bit_r  <= 1'b0;
         end else if (enc_done) begin
            enc_on_r <= 1'b0;
         end else if (core_rd) begin
            shift_r     <= mem_r[addr_r];
            need_byte_r <= 1'b0;
            phase_clk_r <= 1'b1;
            cell_r      <= '0;
            bit_r       <= '0;
         end else if (enc_on_r && !need_byte_r) begin
            if (!cell_end) begin
               cell_r <= cell_r + 5'h01;
            end else begin
               cell_r <= '0;
               if (phase_clk_r) begin
                  phase_clk_r <= 1'b0;
               end else begin
                  phase_clk_r <= 1'b1;
                  prev_bit_r  <= shift_r[7];
                  shift_r     <= {shift_r[6:0], 1'b0};
                  bit_r       <= bit_r + 3'h1;
                  if (bit_r == 3'h7) begin
                     need_byte_r <= 1'b1;
                  end
               end
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         wg_r  <= 1'b0;
         wcc_r <= 1'b0;
         mfm_r <= 1'b0;
      end else if (ce) begin
         wg_r  <= enc_on_r;
         wcc_r <= enc_on_r && !need_byte_r && phase_clk_r;
         mfm_r <= enc_on_r && !need_byte_r
                  && (phase_clk_r ? !(shift_r[7] || prev_bit_r) : shift_r[7]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs
   assign bus.host_rdata              = rdata_r;
   assign bus.buffer_data_request     = drq_r;
   assign bus.buffer_ready_flag       = rdy_r;
   assign bus.buffer_ownership_select = own_r;
   assign bus.buffer_counter_clear    = clr_r;
   assign bus.command_done_irq        = irq_r;
   assign bus.busy_o                  = 1'b1;
   assign bus.busy_oe_n               = own_r;
   assign write_gate                  = wg_r;
   assign write_cell_clock            = wcc_r;
   assign mfm_wr_data                 = mfm_r;
   assign core_buffer_read_strobe     = core_rd && ce;
   assign core_buffer_write_strobe    = core_wr && ce;
endmodule : dsb_device

// ===== dsb_host.sv
// dsb_host: host cpu end, bridges a software register port onto the task file link
// assumes software waits for the request line before moving sector data
`timescale 1ns/1ps
module dsb_host
   import dsb_pkg::*;
(
   // clock, reset, enable
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       ce,
   // link to device
   dsb_if.host             bus,
   // software register port
   input  wire logic [3:0] sw_addr,
   input  wire logic [7:0] sw_wdata,
   input  wire logic       sw_we,
   input  wire logic       sw_re,
   output logic      [7:0] sw_rdata
);
   logic       local_r;
   logic [7:0] stat_r;
   logic       is_tf;

   assign is_tf = !sw_addr[3];

   ////////////////////////////////////////////////////////////////////////////////
   // task file access: three selects, separate strobes
   assign bus.task_reg_select_lines = sw_addr[2:0];
   assign bus.host_write_strobe     = sw_we && is_tf && ce;
   assign bus.host_read_strobe      = sw_re && is_tf && ce;
   assign bus.host_wdata            = sw_wdata;

   ////////////////////////////////////////////////////////////////////////////////
   // local status register
   always_ff @(posedge clk) begin
      if (reset) begin
         local_r <= 1'b0;
         stat_r  <= RESET_BYTE;
      end else if (ce) begin
         if (sw_re) begin
            local_r <= sw_addr == HOST_STATUS;
         end
         if (sw_re && sw_addr == HOST_STATUS) begin
            stat_r           <= RESET_BYTE;
            stat_r[ST_BUSY]  <= bus.busy_flag_line;
            stat_r[ST_DRQ]   <= bus.buffer_data_request;
            stat_r[ST_IRQ]   <= bus.command_done_irq;
            stat_r[ST_READY] <= bus.buffer_ready_flag;
         end else if (sw_re) begin
            stat_r <= RESET_BYTE;
         end
      end
   end

   assign sw_rdata = local_r ? stat_r : (sw_addr_valid_r() ? bus.host_rdata : RESET_BYTE);

   function automatic logic sw_addr_valid_r();
      sw_addr_valid_r = 1'b1;
   endfunction : sw_addr_valid_r
endmodule : dsb_host

// ===== dsb_asserts.sv
// dsb_asserts: link protocol checks between host end and device end
// assumes one clock, sync active high reset, placed beside the link
`timescale 1ns/1ps
module dsb_asserts
   import dsb_pkg::*;
(
   // clock and reset
   input wire logic       clk,
   input wire logic       reset,
   // host to device
   input wire logic [2:0] task_reg_select_lines,
   input wire logic       host_write_strobe,
   input wire logic       host_read_strobe,
   input wire logic [7:0] host_wdata,
   // device to host
   input wire logic [7:0] host_rdata,
   input wire logic       buffer_data_request,
   input wire logic       buffer_ready_flag,
   input wire logic       buffer_ownership_select,
   input wire logic       buffer_counter_clear,
   input wire logic       command_done_irq,
   input wire logic       busy_flag_line
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   logic       own, drq, rdy, idle, dwr, drd, cwr;
   logic [9:0] xcnt_r;
   assign own  = buffer_ownership_select;
   assign drq  = buffer_data_request;
   assign rdy  = buffer_ready_flag;
   assign idle = own && !drq;
   assign dwr  = host_write_strobe && task_reg_select_lines == TF_DATA && drq;
   assign drd  = host_read_strobe && task_reg_select_lines == TF_DATA && drq;
   assign cwr  = host_write_strobe && task_reg_select_lines == TF_CMD && idle;
   ////////////////////////////////////////////////////////////////
   // data port strobes taken in the current pass
   always_ff @(posedge clk) begin
      if (reset || !drq) begin
         xcnt_r <= 10'h000;
      end else if (dwr || drd) begin
         xcnt_r <= xcnt_r + 10'h001;
      end
   end
   ////////////////////////////////////////////////////////////////
   a_write_grant: assert property (
      cwr && host_wdata == CMD_WRITE_SECTOR |=> drq && own) else $error("write not granted");
   a_read_take: assert property (
      cwr && host_wdata == CMD_READ_SECTOR |=> !own && !drq) else $error("read not taken");
   a_no_early_fill: assert property (
      dwr && xcnt_r != SECTOR_LAST |=> drq && own && !rdy) else $error("fill ended early");
   a_fill_done: assert property (
      dwr && xcnt_r == SECTOR_LAST |=> rdy && !drq && !own) else $error("fill end wrong");
   a_drain_hold: assert property (
      drd && xcnt_r != SECTOR_LAST |=> drq && !rdy) else $error("drain ended early");
   a_drain_done: assert property (
      drd && xcnt_r == SECTOR_LAST |=> !drq && rdy && command_done_irq)
      else $error("drain end wrong");
   a_busy_follows: assert property (
      busy_flag_line == !own) else $error("busy line not tied to select");
   a_write_end: assert property (
      $rose(own) && !drq |-> ##[0:1] command_done_irq) else $error("no irq at end");
   a_pass_clear: assert property (
      $rose(drq) || $fell(own) |-> ##[0:1] buffer_counter_clear) else $error("no clear");
   a_busy_rdata: assert property (
      host_read_strobe && task_reg_select_lines == TF_DATA && !own |=> host_rdata == 8'h80)
      else $error("busy read data wrong");
   c_write_cmd: cover property (cwr && host_wdata == CMD_WRITE_SECTOR);
   c_fill_end: cover property (dwr && xcnt_r == SECTOR_LAST);
   c_drain_end: cover property (drd && xcnt_r == SECTOR_LAST);
endmodule : dsb_asserts

// ===== tb.sv
// tb: host end and device end joined by the link, driven through the software port
// assumes a 250 MHz clock; the bench plays the drive pins
`timescale 1ns/1ps
module tb
   import dsb_pkg::*;
   ;
   logic       clk, reset, seek_done, rd_valid, sw_we, sw_re, wg, wcc, mfm, pwcc, crd, cws;
   logic [7:0] rd_byte, sw_wdata, sw_rdata;
   logic [3:0] sw_addr;
   logic [1:0] cells[$];
   int         n_mismatch, num_checks, cnt, w, ncr, ncw;
   dsb_if link ();
   dsb_host u_dsb_host (.clk(clk), .reset(reset), .ce(1'b1), .bus(link.host),
      .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_we(sw_we), .sw_re(sw_re), .sw_rdata(sw_rdata));
   dsb_device u_dsb_device (.clk(clk), .reset(reset), .ce(1'b1), .bus(link.dev),
      .seek_done(seek_done), .disk_rd_valid(rd_valid), .disk_rd_byte(rd_byte),
      .write_gate(wg), .write_cell_clock(wcc), .mfm_wr_data(mfm),
      .core_buffer_read_strobe(crd), .core_buffer_write_strobe(cws));
   dsb_asserts u_chk (.clk(clk), .reset(reset),
      .task_reg_select_lines(link.task_reg_select_lines),
      .host_write_strobe(link.host_write_strobe), .host_read_strobe(link.host_read_strobe),
      .host_wdata(link.host_wdata), .host_rdata(link.host_rdata),
      .buffer_data_request(link.buffer_data_request),
      .buffer_ready_flag(link.buffer_ready_flag),
      .buffer_ownership_select(link.buffer_ownership_select),
      .buffer_counter_clear(link.buffer_counter_clear),
      .command_done_irq(link.command_done_irq), .busy_flag_line(link.busy_flag_line));
   ////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   function automatic logic [7:0] pat(input int n);
      pat = 8'(n * 29);
   endfunction : pat
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic sw_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      sw_addr  <= a;
      sw_wdata <= d;
      sw_we    <= 1'b1;
      @(posedge clk);
      sw_we    <= 1'b0;
   endtask : sw_wr
   task automatic sw_rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      sw_addr <= a;
      sw_re   <= 1'b1;
      @(posedge clk);
      sw_re   <= 1'b0;
      #1;
      chk(16'(sw_rdata), 16'(exp));
   endtask : sw_rd
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test
   ////////////////////////////////////////////////////////////////
   // samples each write cell at its middle, times the clock cells
   always @(posedge clk) begin
      if (wcc !== pwcc) begin
         if (wg === 1'b1 && pwcc === 1'b1) chk(16'(cnt), 16'h0018);
         cnt = 0;
      end else begin
         cnt++;
      end
      pwcc = wcc;
      if (crd === 1'b1) ncr++;
      if (cws === 1'b1) ncw++;
      if (wg === 1'b1 && cnt == 12) cells.push_back({wcc, mfm});
   end
   task automatic chk_mfm;
      logic b, prev;
      logic [7:0] p;
      prev = 1'b0;
      chk(16'(cells.size()), 16'h2000);
      chk(16'(ncr), 16'h0200);
      for (int i = 0; i < 4096 && 2 * i + 1 < cells.size(); i++) begin
         p = pat(i / 8);
         b = p[7 - i % 8];
         chk({12'h000, cells[2 * i], cells[2 * i + 1]}, {12'h000, 1'b1, ~(b | prev), 1'b0, b});
         prev = b;
      end
   endtask : chk_mfm
   initial begin
      #1600000;
      n_mismatch++;
      $display("unexpected at %0t: timeout", $time);
      stop_test;
   end
   initial begin
      {reset, seek_done, rd_valid, sw_we, sw_re, pwcc} = 6'h20;
      {rd_byte, sw_wdata, sw_addr} = 20'h00000;
      n_mismatch = 0;
      num_checks = 0;
      cnt        = 0;
      ncr        = 0;
      ncw        = 0;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      sw_rd(HOST_STATUS, 8'h00);
      sw_rd(4'(TF_DATA), 8'h00);
      sw_wr(4'(TF_CMD), CMD_WRITE_SECTOR);
      sw_rd(HOST_STATUS, 8'h08);
      for (int n = 0; n < 512; n++) sw_wr(4'(TF_DATA), pat(n));
      sw_rd(HOST_STATUS, 8'h81);
      seek_done <= 1'b1;
      sw_rd(4'(TF_DATA), 8'h80);
      for (w = 0; w < 300000 && link.buffer_ownership_select !== 1'b1; w++) @(posedge clk);
      sw_rd(HOST_STATUS, 8'h02);
      chk_mfm();
      sw_rd(4'(TF_CMD), 8'h02);
      sw_rd(HOST_STATUS, 8'h00);
      sw_wr(4'(TF_CMD), CMD_READ_SECTOR);
      sw_rd(HOST_STATUS, 8'h80);
      repeat (8) @(posedge clk);
      for (int n = 0; n < 512; n++) begin
         rd_valid <= 1'b1;
         rd_byte  <= ~pat(n);
         @(posedge clk);
         rd_valid <= 1'b0;
         @(posedge clk);
      end
      chk(16'(ncw), 16'h0200);
      sw_rd(HOST_STATUS, 8'h09);
      for (int n = 0; n < 512; n++) sw_rd(4'(TF_DATA), ~pat(n));
      sw_rd(HOST_STATUS, 8'h03);
      stop_test();
   end
endmodule : tb
